// File: tmr_pkg.sv
// Package with register map, field layout, modes and state type of the 8-bit timer.
package tmr_pkg;

	// Register byte offsets on the bus.
	localparam logic [7:0] TMR_OFS_CTRL  = 8'h00;
	localparam logic [7:0] TMR_OFS_COUNT = 8'h04;
	localparam logic [7:0] TMR_OFS_COMP  = 8'h08;
	localparam logic [7:0] TMR_OFS_ASYNC = 8'h0C;
	localparam logic [7:0] TMR_OFS_FLAG  = 8'h10;
	localparam logic [7:0] TMR_OFS_MASK  = 8'h14;

	// Field positions in the timer control register.
	localparam int TMR_CTRL_FOC    = 7;
	localparam int TMR_CTRL_WGM_LO = 6;
	localparam int TMR_CTRL_COM_HI = 5;
	localparam int TMR_CTRL_COM_LO = 4;
	localparam int TMR_CTRL_WGM_HI = 3;
	localparam int TMR_CTRL_CS_HI  = 2;
	// Field positions in the async status, flag and mask registers.
	localparam int TMR_ASYNC_SEL   = 3;
	localparam int TMR_FLAG_COMP   = 7;
	localparam int TMR_FLAG_OVF    = 6;

	// Counter extremes.
	localparam logic [7:0] TMR_BOTTOM = 8'h00;
	localparam logic [7:0] TMR_MAX    = 8'hFF;

	// Reset values.
	localparam logic [7:0] TMR_RST_BYTE = 8'h00;
	localparam logic [9:0] TMR_RST_PRE  = 10'h000;

	// Prescaler masks per clock select code 1..7: divide by 1, 8, 32, 64, 128, 256, 1024.
	localparam logic [9:0] TMR_PRE_MASK [8] = '{10'h000, 10'h000, 10'h007, 10'h01F,
		10'h03F, 10'h07F, 10'h0FF, 10'h3FF};

	typedef enum logic [1:0] {
		TMR_NORMAL = 2'b00,
		TMR_PHASE  = 2'b01,
		TMR_CTC    = 2'b10,
		TMR_FAST   = 2'b11
	} tmr_mode_type;

	// Pending data phase of an accepted bus transfer.
	typedef struct packed {
		logic       sel;
		logic       wr;
		logic [7:0] ofs;
	} tmr_bus_type;

	typedef struct packed {
		tmr_bus_type  bus;
		logic [31:0]  rdata;
		tmr_mode_type mode;
		logic [1:0]   com;
		logic [2:0]   cs;
		logic         async_sel;
		logic [7:0]   cnt;
		logic [7:0]   ocr;
		logic [7:0]   ocr_buf;
		logic         down;
		logic         block;
		logic         ocf;
		logic         tov;
		logic         ocie;
		logic         toie;
		logic         oc;
		logic         osc_q;
		logic [9:0]   pre;
		logic         comp_irq;
		logic         ovf_irq;
	} tmr_state_type;

endpackage

// File: tmr_timer8.sv
// Top module of the 8-bit timer/counter with one compare unit and an AHB-Lite slave.
// Function
// - Counter and compare value are 8-bit registers.
// - Async select switches timer clock to oscillator.
// - Clock select zero stops the counter.
// - Counter readable and writable without timer clock.
// - CPU counter write beats count or clear.
// - Each tick clears, increments or decrements.
// - Bottom at zero, maximum at 255.
// - Top is 255 or compare value.
// - Wave-mode bits choose counting sequence.
// - Overflow flag per mode, can request interrupt.
// - Match sets compare flag on next tick.
// - Enabled compare flag raises interrupt request.
// - Compare flag clears on service or one.
// - Waveform from match, modes, top and bottom.
// - Compare value double buffered only in PWM.
// - Buffer transfers only at top or bottom.
// - CPU reaches buffer or active compare register.
// - Force strobe forces match in non-PWM modes.
// - Forced match moves output, not flag or counter.
// - Counter write blocks match on next tick.
// - Flags and masks in shared registers.
// - Normal mode wraps, overflow when reaching zero.
// - Clear-on-match mode clears counter on match.
// - Output mode zero leaves output alone.
`timescale 1ns/100ps
module tmr_timer8
	import tmr_pkg::*;
(
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Oscillator input, taken as synchronous to hclk.
	input  wire logic        osc_pin_one,
	// Interrupt service acknowledges.
	input  wire logic        comp_irq_ack,
	input  wire logic        ovf_irq_ack,
	// Interrupt requests and compare output.
	output logic             comp_irq,
	output logic             ovf_irq,
	output logic             compare_output
);

	tmr_state_type s;
	tmr_state_type n;

	logic       wr_en;
	logic       wr_ctrl;
	logic       wr_cnt;
	logic       wr_comp;
	logic       pwm;
	logic       tick;
	logic       match;
	logic [7:0] wbyte;

	assign wbyte   = hwdata[7:0];
	assign wr_en   = s.bus.sel && s.bus.wr;
	assign wr_ctrl = wr_en && (s.bus.ofs == TMR_OFS_CTRL);
	assign wr_cnt  = wr_en && (s.bus.ofs == TMR_OFS_COUNT);
	assign wr_comp = wr_en && (s.bus.ofs == TMR_OFS_COMP);
	assign pwm     = (s.mode == TMR_PHASE) || (s.mode == TMR_FAST);
	// The oscillator steps the prescaler on its rising edge; else every hclk does.
	assign tick    = (s.cs != 3'h0) && (!s.async_sel || (osc_pin_one && !s.osc_q)) &&
		((s.pre & TMR_PRE_MASK[s.cs]) == TMR_PRE_MASK[s.cs]);
	assign match   = (s.cnt == s.ocr) && !s.block;

	assign hrdata         = s.rdata;
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign comp_irq       = s.comp_irq;
	assign ovf_irq        = s.ovf_irq;
	assign compare_output = s.oc;

	always_comb begin
		n = s;
		n.osc_q = osc_pin_one;
		n.rdata = 32'h0000_0000;
		if (s.cs != 3'h0 && (!s.async_sel || (osc_pin_one && !s.osc_q))) begin
			n.pre = s.pre + 10'h001;
		end
		// Address phase: latch the transfer and prepare read data for its data phase.
		n.bus.sel = hsel && htrans[1] && hready;
		n.bus.wr  = hwrite;
		n.bus.ofs = haddr[7:0];
		if (hsel && htrans[1] && hready && !hwrite) begin
			unique case (haddr[7:0])
				TMR_OFS_CTRL:  n.rdata[7:0] = {1'b0, s.mode[0], s.com, s.mode[1], s.cs};
				TMR_OFS_COUNT: n.rdata[7:0] = s.cnt;
				TMR_OFS_COMP:  n.rdata[7:0] = pwm ? s.ocr_buf : s.ocr;
				TMR_OFS_ASYNC: n.rdata[TMR_ASYNC_SEL] = s.async_sel;
				TMR_OFS_FLAG:  n.rdata[7:6] = {s.ocf, s.tov};
				TMR_OFS_MASK:  n.rdata[7:6] = {s.ocie, s.toie};
				default:       n.rdata = 32'h0000_0000;
			endcase
		end
		// Clears come first so that a flag set in the same cycle wins.
		if (comp_irq_ack) begin
			n.ocf = 1'b0;
		end
		if (ovf_irq_ack) begin
			n.tov = 1'b0;
		end
		if (wr_en && s.bus.ofs == TMR_OFS_FLAG) begin
			if (wbyte[TMR_FLAG_COMP]) begin
				n.ocf = 1'b0;
			end
			if (wbyte[TMR_FLAG_OVF]) begin
				n.tov = 1'b0;
			end
		end
		if (tick) begin
			n.block = 1'b0;
			if (match) begin
				n.ocf = 1'b1;
				if (s.com != 2'b00) begin
					unique case (s.mode)
						TMR_NORMAL, TMR_CTC: n.oc = (s.com == 2'b01) ? !s.oc : s.com[0];
						TMR_FAST:            n.oc = (s.com == 2'b01) ? s.oc : s.com[0];
						TMR_PHASE:           n.oc = (s.com == 2'b01) ? s.oc :
							(s.com[0] ^ s.down);
					endcase
				end
			end
			unique case (s.mode)
				TMR_NORMAL: begin
					n.cnt = s.cnt + 8'h01;
					n.tov = n.tov || (s.cnt == TMR_MAX);
				end
				TMR_CTC: begin
					n.cnt = match ? TMR_BOTTOM : s.cnt + 8'h01;
					n.tov = n.tov || (s.cnt == TMR_MAX && !match);
				end
				TMR_FAST: begin
					n.cnt = s.cnt + 8'h01;
					if (s.cnt == TMR_MAX) begin
						n.tov = 1'b1;
						n.ocr = s.ocr_buf;
						if (s.com[1]) begin
							n.oc = !s.com[0];
						end
					end
				end
				TMR_PHASE: begin
					if (!s.down) begin
						if (s.cnt == TMR_MAX) begin
							n.down = 1'b1;
							n.cnt  = s.cnt - 8'h01;
							n.ocr  = s.ocr_buf;
						end else begin
							n.cnt = s.cnt + 8'h01;
						end
					end else begin
						if (s.cnt == TMR_BOTTOM) begin
							n.down = 1'b0;
							n.tov  = 1'b1;
							n.cnt  = s.cnt + 8'h01;
						end else begin
							n.cnt = s.cnt - 8'h01;
						end
					end
				end
			endcase
		end
		// Register writes come last so that they override any counting.
		if (wr_ctrl) begin
			n.mode = tmr_mode_type'({wbyte[TMR_CTRL_WGM_HI], wbyte[TMR_CTRL_WGM_LO]});
			n.com  = wbyte[TMR_CTRL_COM_HI:TMR_CTRL_COM_LO];
			n.cs   = wbyte[TMR_CTRL_CS_HI:0];
			// The strobe acts with the old modes; it never touches flag or counter.
			if (wbyte[TMR_CTRL_FOC] && !pwm && s.com != 2'b00) begin
				n.oc = (s.com == 2'b01) ? !s.oc : s.com[0];
			end
		end
		if (wr_cnt) begin
			n.cnt   = wbyte;
			n.block = 1'b1;
		end
		if (wr_comp) begin
			n.ocr_buf = wbyte;
			if (!pwm) begin
				n.ocr = wbyte;
			end
		end
		if (wr_en && s.bus.ofs == TMR_OFS_ASYNC) begin
			n.async_sel = wbyte[TMR_ASYNC_SEL];
		end
		if (wr_en && s.bus.ofs == TMR_OFS_MASK) begin
			n.ocie = wbyte[TMR_FLAG_COMP];
			n.toie = wbyte[TMR_FLAG_OVF];
		end
		n.comp_irq = n.ocf && n.ocie;
		n.ovf_irq  = n.tov && n.toie;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s           <= '0;
			s.mode      <= TMR_NORMAL;
			s.cnt       <= TMR_RST_BYTE;
			s.ocr       <= TMR_RST_BYTE;
			s.ocr_buf   <= TMR_RST_BYTE;
			s.pre       <= TMR_RST_PRE;
		end else begin
			s <= n;
		end
	end

	sequence s_cnt_write;
		wr_cnt;
	endsequence

	// First tick after a counter write; the write leaves the block raised until then.
	sequence s_blocked_tick;
		tick && s.block;
	endsequence

	property p_stopped;
		@(posedge hclk) disable iff (!hresetn)
		(s.cs == 3'h0 && !wr_cnt) |=> $stable(s.cnt);
	endproperty
	a_stopped: assert property (p_stopped) else $error("Counter moved with no clock.");

	property p_cnt_write;
		@(posedge hclk) disable iff (!hresetn)
		s_cnt_write |=> (s.cnt == $past(hwdata[7:0]));
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("Counter write lost.");

	property p_block;
		@(posedge hclk) disable iff (!hresetn)
		(s_blocked_tick ##0 !s.ocf) |=> !s.ocf;
	endproperty
	a_block: assert property (p_block) else $error("Match not blocked after write.");

	property p_ocf_clear;
		@(posedge hclk) disable iff (!hresetn)
		(comp_irq_ack && !(tick && match)) |=> !s.ocf;
	endproperty
	a_ocf_clear: assert property (p_ocf_clear) else $error("Compare flag kept after ack.");

	property p_tov_w1c;
		@(posedge hclk) disable iff (!hresetn)
		(wr_en && s.bus.ofs == TMR_OFS_FLAG && wbyte[TMR_FLAG_OVF] && !tick) |=> !s.tov;
	endproperty
	a_tov_w1c: assert property (p_tov_w1c) else $error("Overflow flag kept after clear.");

	property p_ovf_irq;
		@(posedge hclk) disable iff (!hresetn)
		(s.tov && s.toie) |-> ovf_irq;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("Overflow request missing.");

	property p_ctc_ovf;
		@(posedge hclk) disable iff (!hresetn)
		(tick && s.mode == TMR_CTC && s.cnt == TMR_MAX && !match && !wr_cnt && !wr_ctrl)
			|=> (s.cnt == TMR_BOTTOM && s.tov);
	endproperty
	a_ctc_ovf: assert property (p_ctc_ovf) else $error("Clear-on-match wrap wrong.");

	property p_fast_wrap;
		@(posedge hclk) disable iff (!hresetn)
		(tick && s.mode == TMR_FAST && s.cnt == TMR_MAX && !wr_cnt && !wr_ctrl)
			|=> (s.cnt == TMR_BOTTOM && s.tov && s.ocr == $past(s.ocr_buf));
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("Fast mode wrap wrong.");

	property p_fast_clear;
		@(posedge hclk) disable iff (!hresetn)
		(tick && s.mode == TMR_FAST && match && s.com == 2'b10 && s.cnt != TMR_MAX && !wr_ctrl)
			|=> !compare_output;
	endproperty
	a_fast_clear: assert property (p_fast_clear) else $error("Output not cleared.");

	property p_phase_bottom;
		@(posedge hclk) disable iff (!hresetn)
		(tick && s.mode == TMR_PHASE && s.down && s.cnt == TMR_BOTTOM && !wr_cnt && !wr_ctrl)
			|=> (!s.down && s.cnt == 8'h01 && s.tov);
	endproperty
	a_phase_bottom: assert property (p_phase_bottom) else $error("No turn at bottom.");

	property p_comp_direct;
		@(posedge hclk) disable iff (!hresetn)
		(wr_comp && !pwm) |=> (s.ocr == $past(wbyte));
	endproperty
	a_comp_direct: assert property (p_comp_direct) else $error("Direct compare write lost.");

	property p_comp_buffer;
		@(posedge hclk) disable iff (!hresetn)
		wr_comp |=> (s.ocr_buf == $past(wbyte));
	endproperty
	a_comp_buffer: assert property (p_comp_buffer) else $error("Buffer write lost.");

	property p_com_zero;
		@(posedge hclk) disable iff (!hresetn)
		(tick && match && s.com == 2'b00 && !wr_ctrl) |=> $stable(compare_output);
	endproperty
	a_com_zero: assert property (p_com_zero) else $error("Output moved in mode zero.");

	property p_async_idle;
		@(posedge hclk) disable iff (!hresetn)
		(s.async_sel && !osc_pin_one) |-> !tick;
	endproperty
	a_async_idle: assert property (p_async_idle) else $error("Tick without oscillator.");

	property p_sync_tick;
		@(posedge hclk) disable iff (!hresetn)
		(s.cs == 3'h1 && !s.async_sel) |-> tick;
	endproperty
	a_sync_tick: assert property (p_sync_tick) else $error("Undivided tick missing.");

	property p_rdata_idle;
		@(posedge hclk) disable iff (!hresetn)
		!(hsel && htrans[1] && hready && !hwrite) |=> (hrdata == 32'h0000_0000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("Read data left standing.");

	property p_read_count;
		@(posedge hclk) disable iff (!hresetn)
		(hsel && htrans[1] && hready && !hwrite && haddr[7:0] == TMR_OFS_COUNT)
			|=> (hrdata == {24'h00_0000, $past(s.cnt)});
	endproperty
	a_read_count: assert property (p_read_count) else $error("Counter read wrong.");

	property p_ocf_set;
		@(posedge hclk) disable iff (!hresetn)
		(tick && match) |=> s.ocf;
	endproperty
	a_ocf_set: assert property (p_ocf_set) else $error("Compare flag not set.");

	property p_wrap;
		@(posedge hclk) disable iff (!hresetn)
		(tick && s.mode == TMR_NORMAL && s.cnt == TMR_MAX && !wr_cnt && !wr_ctrl)
			|=> (s.cnt == TMR_BOTTOM && s.tov);
	endproperty
	a_wrap: assert property (p_wrap) else $error("Normal mode wrap wrong.");

	property p_ctc;
		@(posedge hclk) disable iff (!hresetn)
		(tick && s.mode == TMR_CTC && match && !wr_cnt) |=> (s.cnt == TMR_BOTTOM);
	endproperty
	a_ctc: assert property (p_ctc) else $error("Counter not cleared on match.");

	property p_buffered;
		@(posedge hclk) disable iff (!hresetn)
		(pwm && !wr_ctrl && !(tick && s.cnt == TMR_MAX)) |=> $stable(s.ocr);
	endproperty
	a_buffered: assert property (p_buffered) else $error("Compare value moved mid-cycle.");

	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		(s.ocf && s.ocie) |-> comp_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("Compare request missing.");

	property p_force;
		@(posedge hclk) disable iff (!hresetn)
		(wr_ctrl && hwdata[TMR_CTRL_FOC] && !pwm && s.com == 2'b01 && !tick)
			|=> (compare_output != $past(compare_output)) && ($past(s.ocf) || !s.ocf);
	endproperty
	a_force: assert property (p_force) else $error("Forced match misbehaved.");

	property p_phase_turn;
		@(posedge hclk) disable iff (!hresetn)
		(tick && s.mode == TMR_PHASE && !s.down && s.cnt == TMR_MAX && !wr_cnt && !wr_ctrl)
			|=> (s.down && s.cnt == 8'hFE);
	endproperty
	a_phase_turn: assert property (p_phase_turn) else $error("No turn at maximum.");

endmodule

// File: tmr_partner.sv
// Model of the interrupt service side and of the watch oscillator of the timer.
`timescale 1ns/100ps
module tmr_partner #(
	parameter int ACK_DELAY = 3
) (
	// Clock and reset.
	input  wire logic hclk,
	input  wire logic hresetn,
	// Requests and oscillator enable.
	input  wire logic comp_irq,
	input  wire logic ovf_irq,
	input  wire logic osc_run,
	// Acknowledges and oscillator pin.
	output logic      comp_irq_ack,
	output logic      ovf_irq_ack,
	output logic      osc_pin_one
);
	logic [7:0] c_wait;
	logic [7:0] o_wait;
	logic [1:0] div;
	// The oscillator stands low while stopped, so no stray edge reaches the prescaler.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			c_wait <= 8'h00;
			o_wait <= 8'h00;
			div <= 2'h0;
			comp_irq_ack <= 1'b0;
			ovf_irq_ack <= 1'b0;
			osc_pin_one <= 1'b0;
		end else begin
			c_wait <= comp_irq ? c_wait + 8'h01 : 8'h00;
			o_wait <= ovf_irq ? o_wait + 8'h01 : 8'h00;
			comp_irq_ack <= comp_irq && (c_wait == ACK_DELAY[7:0]);
			ovf_irq_ack <= ovf_irq && (o_wait == ACK_DELAY[7:0]);
			div <= osc_run ? div + 2'h1 : 2'h0;
			osc_pin_one <= osc_run && div[1];
		end
	end
endmodule

// File: tmr_timer8_tb.sv
// Self-checking testbench of the 8-bit timer with its partner model.
`timescale 1ns/100ps
module tmr_timer8_tb
	import tmr_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        osc_run;
	logic        o;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  r;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rs;
	logic [31:0] v;
	logic        hreadyout;
	logic        hresp;
	logic        comp_irq;
	logic        ovf_irq;
	logic        compare_output;
	logic        comp_ack;
	logic        ovf_ack;
	logic        osc;
	int          hi_n;
	int          lo_n;
	int          err_total;
	int          compares;

	tmr_timer8 u_tmr_timer8 (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_pin_one(osc),
		.comp_irq_ack(comp_ack), .ovf_irq_ack(ovf_ack), .comp_irq(comp_irq),
		.ovf_irq(ovf_irq), .compare_output(compare_output));
	tmr_partner u_tmr_partner (.hclk(hclk), .hresetn(hresetn), .comp_irq(comp_irq),
		.ovf_irq(ovf_irq), .osc_run(osc_run), .comp_irq_ack(comp_ack),
		.ovf_irq_ack(ovf_ack), .osc_pin_one(osc));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] c,
		input logic [2:0] s, input logic f);
		return {f, m[0], c, m[1], s};
	endfunction

	// Output expected after a forced match, from the output mode and the old level.
	function automatic logic fexp(input logic [1:0] c, input logic old);
		return c[1] ? c[0] : (c[0] ? ~old : old);
	endfunction

	task automatic report_and_stop;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic waitrdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64) begin
			err_total++;
			report_and_stop;
		end
	endtask

	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		waitrdy;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		waitrdy;
		v = hrdata;
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 8'h00);
		chk(nm, v, 32'(e));
	endtask

	task automatic waitirq(input logic sel, input string nm);
		int n;
		n = 0;
		while ((sel ? comp_irq : ovf_irq) !== 1'b1 && n < 400) begin
			@(posedge hclk);
			n++;
		end
		chk(nm, 32'(n < 400), 32'h1);
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		osc_run = 1'b0;
		rs = 32'd33041;
		err_total = 0;
		compares = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 0; a <= 24; a += 4) rdc("reset_value", a[7:0], 8'h00);
		xfer(TMR_OFS_COUNT, 1'b1, 8'h37);
		repeat (10) @(posedge hclk);
		rdc("stopped_count", TMR_OFS_COUNT, 8'h37);
		$display("test stop done");
		for (int c = 0; c < 4; c++) begin
			o = compare_output;
			xfer(TMR_OFS_CTRL, 1'b1, ctl(2'b00, c[1:0], 3'h0, 1'b0));
			xfer(TMR_OFS_CTRL, 1'b1, ctl(2'b00, c[1:0], 3'h0, 1'b1));
			xfer(TMR_OFS_FLAG, 1'b0, 8'h00);
			chk("force_flag", v, 32'h0);
			chk("force_out", 32'(compare_output), 32'(fexp(c[1:0], o)));
		end
		rdc("force_count", TMR_OFS_COUNT, 8'h37);
		$display("test force done");
		xfer(TMR_OFS_COMP, 1'b1, 8'h20);
		xfer(TMR_OFS_COUNT, 1'b1, 8'h20);
		xfer(TMR_OFS_CTRL, 1'b1, ctl(2'b00, 2'b00, 3'h1, 1'b0));
		rdc("blocked", TMR_OFS_FLAG, 8'h00);
		xfer(TMR_OFS_MASK, 1'b1, 8'h80);
		waitirq(1'b1, "comp_irq");
		repeat (6) @(posedge hclk);
		chk("comp_ack", 32'(comp_irq), 32'h0);
		xfer(TMR_OFS_MASK, 1'b1, 8'h00);
		xfer(TMR_OFS_FLAG, 1'b1, 8'hC0);
		repeat (300) @(posedge hclk);
		rdc("flags_set", TMR_OFS_FLAG, 8'hC0);
		xfer(TMR_OFS_FLAG, 1'b1, 8'h80);
		rdc("w1c", TMR_OFS_FLAG, 8'h40);
		xfer(TMR_OFS_MASK, 1'b1, 8'h40);
		waitirq(1'b0, "ovf_irq");
		repeat (6) @(posedge hclk);
		chk("ovf_ack", 32'(ovf_irq), 32'h0);
		$display("test flags done");
		for (int i = 0; i < 6; i++) begin
			rs = xs(rs);
			r = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : rs[7:0]);
			xfer(TMR_OFS_CTRL, 1'b1, ctl(2'b10, 2'b00, 3'h0, 1'b0));
			xfer(TMR_OFS_COMP, 1'b1, r);
			xfer(TMR_OFS_COUNT, 1'b1, 8'h00);
			xfer(TMR_OFS_CTRL, 1'b1, ctl(2'b10, 2'b00, 3'h1, 1'b0));
			// With compare value zero the write blocks the first match, so let one full wrap pass first.
			repeat (300) @(posedge hclk);
			repeat (3) begin
				xfer(TMR_OFS_COUNT, 1'b0, 8'h00);
				chk("ctc_top", 32'(v[7:0] <= r), 32'h1);
			end
		end
		$display("test ctc done");
		for (int m = 1; m < 4; m += 2) begin
			xfer(TMR_OFS_CTRL, 1'b1, ctl(m[1:0], 2'b10, 3'h1, 1'b0));
			xfer(TMR_OFS_COMP, 1'b1, 8'h80);
			rdc("pwm_buffer", TMR_OFS_COMP, 8'h80);
			hi_n = 0;
			lo_n = 0;
			repeat (600) begin
				@(posedge hclk);
				if (compare_output === 1'b1) begin
					hi_n++;
				end else begin
					lo_n++;
				end
			end
			chk("pwm_high", 32'(hi_n > 0), 32'h1);
			chk("pwm_low", 32'(lo_n > 0), 32'h1);
		end
		$display("test pwm done");
		xfer(TMR_OFS_CTRL, 1'b1, ctl(2'b00, 2'b00, 3'h0, 1'b0));
		xfer(TMR_OFS_COUNT, 1'b1, 8'h00);
		xfer(TMR_OFS_ASYNC, 1'b1, 8'h08);
		xfer(TMR_OFS_CTRL, 1'b1, ctl(2'b00, 2'b00, 3'h1, 1'b0));
		repeat (20) @(posedge hclk);
		rdc("async_idle", TMR_OFS_COUNT, 8'h00);
		osc_run <= 1'b1;
		repeat (40) @(posedge hclk);
		osc_run <= 1'b0;
		xfer(TMR_OFS_COUNT, 1'b0, 8'h00);
		chk("async_run", 32'(v[7:0] != 8'h00), 32'h1);
		$display("test async done");
		report_and_stop;
	end
endmodule
